// ==== src/rsv_bank.sv ====
// rsv_bank.sv: rail setup and input protection register bank, top level
// assumes a bus engine presenting one-cycle write and read strobes with 8-bit command code
`timescale 1ns/1ps
`default_nettype none
`include "rsv_regs.svh"
module rsv_bank (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        i_WR,
    input  wire logic        i_RD,
    input  wire logic [7:0]  i_CMD,
    input  wire logic [15:0] i_WDATA,
    input  wire logic [6:0]  i_VIN_CODE,
    input  wire logic        i_OV_LATCH_MODE,
    input  wire logic        i_RESTART,
    output logic [15:0]      o_RDATA,
    output logic             o_RVALID,
    output logic             o_RERR,
    output logic             o_SLOPE_EN,
    output logic [5:0]       o_SLOPE_CODE,
    output logic [15:0]      o_SLOPE_MV_X1000,
    output logic [8:0]       o_FREQ_CODE,
    output logic             o_REG_RUN,
    output logic             o_OV_FAULT,
    output logic [1:0]       o_PROT_STATE
);
    logic [15:0] slope_reg;
    logic [15:0] freq_reg;
    logic [15:0] uv_rise_reg;
    logic [15:0] uv_fall_reg;
    logic [15:0] ov_reg;
    logic [15:0] rdata_next;
    logic        hit;
    logic        ov_fault_reg;
    logic        run_reg;
    logic [1:0]  state_reg;
    logic [15:0] mv_reg;

    rsv_prot_if pif ();

    wire sel_slope = i_CMD == `RSV_OFS_SLOPE;
    wire sel_freq  = i_CMD == `RSV_OFS_FREQ;
    wire sel_rise  = i_CMD == `RSV_OFS_UV_RISE;
    wire sel_fall  = i_CMD == `RSV_OFS_UV_FALL;
    wire sel_ov    = i_CMD == `RSV_OFS_OV;

    always_comb begin
        hit = 1'b1;
        if (sel_slope) begin
            rdata_next = slope_reg;
        end else if (sel_freq) begin
            rdata_next = freq_reg;
        end else if (sel_rise) begin
            rdata_next = uv_rise_reg;
        end else if (sel_fall) begin
            rdata_next = uv_fall_reg;
        end else if (sel_ov) begin
            rdata_next = ov_reg;
        end else begin
            rdata_next = 16'h0000;
            hit = 1'b0;
        end
    end

    // reserved bits masked at write so they can only ever read zero
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            slope_reg   <= `RSV_RST_SLOPE;
            freq_reg    <= `RSV_RST_FREQ;
            uv_rise_reg <= `RSV_RST_UV_RISE;
            uv_fall_reg <= `RSV_RST_UV_FALL;
            ov_reg      <= `RSV_RST_OV;
        end else if (i_WR) begin
            if (sel_slope) slope_reg <= i_WDATA & `RSV_SLOPE_MASK;
            if (sel_freq) freq_reg <= i_WDATA & `RSV_FREQ_MASK;
            if (sel_rise) uv_rise_reg <= i_WDATA & `RSV_VIN_MASK;
            if (sel_fall) uv_fall_reg <= i_WDATA & `RSV_VIN_MASK;
            if (sel_ov) ov_reg <= i_WDATA & `RSV_VIN_MASK;
        end
    end

    assign pif.uv_rise    = uv_rise_reg[6:0];
    assign pif.uv_fall    = uv_fall_reg[6:0];
    assign pif.ov_level   = ov_reg[6:0];
    assign pif.latch_mode = i_OV_LATCH_MODE;
    assign pif.restart    = i_RESTART;
    assign pif.vin_code   = i_VIN_CODE;

    rsv_prot u_prot (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .p      (pif.prot)
    );

    // fault flag is sticky until a read of the ov register; a new trip wins over the clear
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            o_RDATA      <= 16'h0000;
            o_RVALID     <= 1'b0;
            o_RERR       <= 1'b0;
            ov_fault_reg <= 1'b0;
            run_reg      <= 1'b0;
            state_reg    <= 2'b01;
            mv_reg       <= 16'h0000;
        end else begin
            o_RDATA      <= i_RD ? rdata_next : 16'h0000;
            o_RVALID     <= i_RD;
            o_RERR       <= (i_RD || i_WR) && !hit;
            ov_fault_reg <= pif.ov_trip | (ov_fault_reg & ~(i_RD & sel_ov));
            run_reg      <= pif.run;
            state_reg    <= pif.state;
            mv_reg       <= 16'(slope_reg[5:0] * `RSV_SLOPE_MV_MUL);
        end
    end

    assign o_SLOPE_EN       = slope_reg[`RSV_SLOPE_EN_BIT];
    assign o_SLOPE_CODE     = slope_reg[5:0];
    assign o_SLOPE_MV_X1000 = mv_reg;
    assign o_FREQ_CODE      = freq_reg[8:0];
    assign o_REG_RUN        = run_reg;
    assign o_OV_FAULT       = ov_fault_reg;
    assign o_PROT_STATE     = state_reg;
endmodule
`default_nettype wire

// ==== inc/rsv_regs.svh ====
// rsv_regs.svh: offsets, field positions, reset values of the rail setup register bank
// assumes inclusion by bare name; definitions only
//
// Contract
// - reserved bits ignore writes and always read as zero
// - initial-slope bit 6 enables startup slope compensation before first pulse
// - initial-slope bits 5:0 hold slope current code, quarter microamp per count
// - initial slope voltage in millivolts equals code times 0.845
// - frequency bits 8:0 hold switching code, 10 kHz per count
// - uvlo rise bits 6:0 hold release threshold, 0.25 V per count
// - uvlo fall bits 6:0 hold trip threshold, 0.25 V per count
// - latch-off mode keeps regulation off until operation, enable toggle or power cycle
// - auto-retry mode stops while above threshold, restarts when input falls below
`ifndef RSV_REGS_SVH
`define RSV_REGS_SVH
`define RSV_OFS_SLOPE     8'h2c
`define RSV_OFS_FREQ      8'h33
`define RSV_OFS_UV_RISE   8'h35
`define RSV_OFS_UV_FALL   8'h36
`define RSV_OFS_OV        8'h55
`define RSV_SLOPE_EN_BIT  6
`define RSV_SLOPE_MASK    16'h007f
`define RSV_FREQ_MASK     16'h01ff
`define RSV_VIN_MASK      16'h007f
`define RSV_RST_SLOPE     16'h0000
`define RSV_RST_FREQ      16'h0032
`define RSV_RST_UV_RISE   16'h0020
`define RSV_RST_UV_FALL   16'h001c
`define RSV_RST_OV        16'h0040
// 0.845 scaled by 1000: mv_x1000 = code * 845
`define RSV_SLOPE_MV_MUL  10'h34d
`endif

// ==== inc/rsv_pkg.sv ====
// rsv_pkg.sv: types of the rail setup register bank
// assumes nothing beyond a SystemVerilog compiler
package rsv_pkg;
    typedef enum logic [1:0] {
        RSV_RUN     = 2'b00,
        RSV_LOCKOUT = 2'b01,
        RSV_OV_LATCH = 2'b10,
        RSV_OV_RETRY = 2'b11
    } rsv_state_e;
endpackage

// ==== inc/rsv_prot_if.sv ====
// rsv_prot_if.sv: thresholds and status between register bank and protection logic
// assumes one clock domain on both sides
`timescale 1ns/1ps
`default_nettype none
interface rsv_prot_if;
    logic [6:0] uv_rise;
    logic [6:0] uv_fall;
    logic [6:0] ov_level;
    logic       latch_mode;
    logic       restart;
    logic [6:0] vin_code;
    logic       run;
    logic       ov_trip;
    rsv_pkg::rsv_state_e state;
    modport bank (output uv_rise, uv_fall, ov_level, latch_mode, restart, vin_code,
                  input run, ov_trip, state);
    modport prot (input uv_rise, uv_fall, ov_level, latch_mode, restart, vin_code,
                  output run, ov_trip, state);
endinterface
`default_nettype wire

// ==== src/rsv_prot.sv ====
// rsv_prot.sv: input undervoltage lockout and overvoltage response state machine
// assumes vin code sampled in the same 0.25 V units as the thresholds
`timescale 1ns/1ps
`default_nettype none
module rsv_prot (
    input  wire logic   i_clk,
    input  wire logic   i_rstn,
    rsv_prot_if.prot    p
);
    rsv_pkg::rsv_state_e state_reg;
    rsv_pkg::rsv_state_e state_next;
    wire above_rise = p.vin_code > p.uv_rise;
    wire below_fall = p.vin_code < p.uv_fall;
    wire above_ov   = p.vin_code > p.ov_level;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rsv_pkg::RSV_LOCKOUT: begin
                if (above_ov) begin
                    state_next = p.latch_mode ? rsv_pkg::RSV_OV_LATCH : rsv_pkg::RSV_OV_RETRY;
                end else if (above_rise) begin
                    state_next = rsv_pkg::RSV_RUN;
                end
            end
            rsv_pkg::RSV_RUN: begin
                if (above_ov) begin
                    state_next = p.latch_mode ? rsv_pkg::RSV_OV_LATCH : rsv_pkg::RSV_OV_RETRY;
                end else if (below_fall) begin
                    state_next = rsv_pkg::RSV_LOCKOUT;
                end
            end
            rsv_pkg::RSV_OV_LATCH: begin
                // only an explicit restart leaves, never the input falling
                if (p.restart) begin
                    state_next = rsv_pkg::RSV_LOCKOUT;
                end
            end
            rsv_pkg::RSV_OV_RETRY: begin
                if (!above_ov) begin
                    state_next = rsv_pkg::RSV_LOCKOUT;
                end
            end
            default: state_next = rsv_pkg::RSV_LOCKOUT;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= rsv_pkg::RSV_LOCKOUT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign p.state   = state_reg;
    assign p.run     = state_reg == rsv_pkg::RSV_RUN;
    assign p.ov_trip = above_ov && (state_reg == rsv_pkg::RSV_RUN ||
                                    state_reg == rsv_pkg::RSV_LOCKOUT);
endmodule
`default_nettype wire

// ==== verification/rsv_bank_asserts.sv ====
// rsv_bank_asserts.sv: port checker for the rail setup bank
// assumes a bind onto rsv_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rsv_bank_asserts (
    input wire logic        I_CLK,
    input wire logic        I_RSTN,
    input wire logic        i_WR,
    input wire logic        i_RD,
    input wire logic [7:0]  i_CMD,
    input wire logic [15:0] i_WDATA,
    input wire logic        i_RESTART,
    input wire logic [15:0] o_RDATA,
    input wire logic        o_RVALID,
    input wire logic        o_RERR,
    input wire logic        o_SLOPE_EN,
    input wire logic [5:0]  o_SLOPE_CODE,
    input wire logic [15:0] o_SLOPE_MV_X1000,
    input wire logic [8:0]  o_FREQ_CODE,
    input wire logic        o_REG_RUN,
    input wire logic        o_OV_FAULT,
    input wire logic [1:0]  o_PROT_STATE
);
    wire mapped = i_CMD inside {8'h2c, 8'h33, 8'h35, 8'h36, 8'h55};
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    AST_READ_ANSWER: assert property (i_RD && mapped |=> o_RVALID)
        else $error("read not answered");
    AST_RESERVED_ZERO: assert property (o_RVALID |-> o_RDATA[15:9] == 7'h00)
        else $error("reserved read bits set");
    AST_UNMAPPED_ERR: assert property ((i_RD || i_WR) && !mapped |=> o_RERR)
        else $error("unmapped access not flagged");
    AST_UNMAPPED_ZERO: assert property (i_RD && !mapped |=> o_RDATA == 16'h0000)
        else $error("unmapped read data not zero");
    AST_SLOPE_WRITE: assert property (i_WR && i_CMD == 8'h2c |=>
        {o_SLOPE_EN, o_SLOPE_CODE} == $past(i_WDATA[6:0])) else $error("slope write lost");
    AST_FREQ_WRITE: assert property (i_WR && i_CMD == 8'h33 |=>
        o_FREQ_CODE == $past(i_WDATA[8:0])) else $error("frequency write lost");
    AST_SLOPE_MV: assert property (o_SLOPE_MV_X1000 == 16'($past(o_SLOPE_CODE)) * 16'h034d)
        else $error("slope voltage wrong");
    AST_RUN_STATE: assert property (o_REG_RUN |-> o_PROT_STATE == 2'b00)
        else $error("running outside run state");
    AST_LATCH_HOLD: assert property (o_PROT_STATE == 2'b10 && !i_RESTART
        && !$past(i_RESTART) |=> o_PROT_STATE == 2'b10) else $error("latch left early");
    AST_FAULT_FLAG: assert property ($rose(o_PROT_STATE[1]) |-> ##[0:2] o_OV_FAULT)
        else $error("fault flag missing");
    COV_LATCH: cover property (o_PROT_STATE == 2'b10);
    COV_RETRY: cover property (o_PROT_STATE == 2'b11);
    COV_RUN: cover property ($rose(o_REG_RUN));
    COV_REFUSED: cover property (o_RERR);
endmodule
bind rsv_bank rsv_bank_asserts rsv_bank_asserts_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .i_WR(i_WR), .i_RD(i_RD), .i_CMD(i_CMD), .i_WDATA(i_WDATA), .i_RESTART(i_RESTART),
    .o_RDATA(o_RDATA), .o_RVALID(o_RVALID), .o_RERR(o_RERR), .o_SLOPE_EN(o_SLOPE_EN),
    .o_SLOPE_CODE(o_SLOPE_CODE), .o_SLOPE_MV_X1000(o_SLOPE_MV_X1000),
    .o_FREQ_CODE(o_FREQ_CODE), .o_REG_RUN(o_REG_RUN), .o_OV_FAULT(o_OV_FAULT),
    .o_PROT_STATE(o_PROT_STATE));
`default_nettype wire

// ==== verification/rsv_host.sv ====
// rsv_host.sv: host side model issuing one-cycle register strobes
// assumes the bank answers one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module rsv_host (
    input wire logic         clk,
    output logic             wr,
    output logic             rd,
    output logic [7:0]       cmd,
    output logic [15:0]      wdata,
    input wire logic [15:0]  rdata,
    input wire logic         rvalid,
    input wire logic         rerr
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        cmd = 8'h00;
        wdata = 16'h0000;
    end
    // answer folded into one word: e000 flags a refused write, ffff no data
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        cmd <= c;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        wdata <= ~d;
        #1;
        q = rvalid ? rdata : (rerr ? 16'he000 : 16'hffff);
    endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// testbench.sv: directed scenarios for the rail setup bank
// assumes rsv_host drives the strobes and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rstn, restart, mode, wr, rd, rvalid, rerr, sl_en, run, fault;
    logic [6:0]  vin;
    logic [7:0]  cmd;
    logic [15:0] wdata, rdata, mv, q;
    logic [5:0]  sl_code;
    logic [8:0]  freq;
    logic [1:0]  st;
    int          err_total = 0;
    int          checks_done = 0;
    rsv_bank rsv_bank_i (.I_CLK(clk), .I_RSTN(rstn), .i_WR(wr), .i_RD(rd), .i_CMD(cmd),
        .i_WDATA(wdata), .i_VIN_CODE(vin), .i_OV_LATCH_MODE(mode), .i_RESTART(restart),
        .o_RDATA(rdata), .o_RVALID(rvalid), .o_RERR(rerr), .o_SLOPE_EN(sl_en),
        .o_SLOPE_CODE(sl_code), .o_SLOPE_MV_X1000(mv), .o_FREQ_CODE(freq),
        .o_REG_RUN(run), .o_OV_FAULT(fault), .o_PROT_STATE(st));
    rsv_host rsv_host_i (.clk(clk), .wr(wr), .rd(rd), .cmd(cmd), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid), .rerr(rerr));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        rsv_host_i.xfer(1'b0, c, 16'h0000, q);
        chk(q, e);
    endtask
    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
        rsv_host_i.xfer(1'b1, c, d, q);
    endtask
    task automatic vin_to(input logic [6:0] v);
        @(posedge clk);
        vin <= v;
        repeat (4) @(posedge clk);
        #1;
    endtask
    logic [7:0]  ofs [5] = '{8'h2c, 8'h33, 8'h35, 8'h36, 8'h55};
    logic [15:0] rst [5] = '{16'h0000, 16'h0032, 16'h0020, 16'h001c, 16'h0040};
    logic [15:0] msk [5] = '{16'h007f, 16'h01ff, 16'h007f, 16'h007f, 16'h007f};
    task automatic t_reset;
        foreach (ofs[i]) rd_chk(ofs[i], rst[i]);
    endtask
    task automatic t_regs;
        foreach (ofs[i]) begin
            wr_reg(ofs[i], 16'hffff);
            rd_chk(ofs[i], msk[i]);
        end
        chkb(sl_en, 1'b1);
        chk({7'h00, freq}, 16'h01ff);
        wr_reg(8'h2c, 16'h0030);
        rd_chk(8'h2c, 16'h0030);
        chk({10'h000, sl_code}, 16'h0030);
        chkb(sl_en, 1'b0);
        // 48 counts times 845
        chk(mv, 16'h9e70);
        wr_reg(8'h34, 16'hffff);
        chk(q, 16'he000);
        // an unmapped read still answers, with zero data and the error pulse
        rd_chk(8'h34, 16'h0000);
        chkb(rerr, 1'b1);
    endtask
    task automatic t_uvlo;
        wr_reg(8'h35, 16'h0020);
        wr_reg(8'h36, 16'h001c);
        wr_reg(8'h55, 16'h0040);
        vin_to(7'h1e);
        chkb(run, 1'b0);
        vin_to(7'h21);
        chkb(run, 1'b1);
        vin_to(7'h1d);
        chkb(run, 1'b1);
        vin_to(7'h1b);
        chkb(run, 1'b0);
    endtask
    task automatic t_ov;
        vin_to(7'h21);
        vin_to(7'h41);
        chk({14'h0000, st}, 16'h0003);
        chkb(fault, 1'b1);
        vin_to(7'h40);
        chkb(run, 1'b1);
        rd_chk(8'h55, 16'h0040);
        chkb(fault, 1'b0);
        @(posedge clk);
        mode <= 1'b1;
        vin_to(7'h41);
        chkb(fault, 1'b1);
        vin_to(7'h21);
        chk({14'h0000, st}, 16'h0002);
        chkb(run, 1'b0);
        @(posedge clk);
        restart <= 1'b1;
        vin_to(7'h21);
        chkb(run, 1'b1);
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (restart) restart <= 1'b0;
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        print_verdict;
    end
    initial begin
        {rstn, restart, mode, vin} = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_regs;
        t_uvlo;
        t_ov;
        print_verdict;
    end
endmodule
`default_nettype wire
